// ### bench/chip_cfg_asserts.sv
/* port checker for the sync and mode configuration bank
   assumes a bind onto chip_sync_and_mode_config, one clock */
`timescale 1ns/100ps
module chip_cfg_asserts (
   input wire       ref_clk,
   input wire       srst,
   input wire       cyc_i,
   input wire       stb_i,
   input wire       ack_o,
   input wire       divider_reset,
   input wire       link_restart,
   input wire       monitor_restart,
   input wire       sample_tag,
   input wire [3:0] divider_phase,
   input wire       full_bandwidth,
   input wire       downconverter_channel_0,
   input wire       downconverter_channel_1,
   input wire       downconverter_channel_2,
   input wire       downconverter_channel_3,
   input wire       downconverter_bypass,
   input wire [3:0] decimation_code
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("no ack one cycle after request");
   ack_single_a: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   div_mon_pair_a: assert property (divider_reset == monitor_restart)
      else $error("divider and monitor restart differ");
   div_spacing_a: assert property (divider_reset |=> !divider_reset)
      else $error("divider reset pulse too long");
   link_drop_a: assert property (link_restart |-> divider_reset)
      else $error("link drop without divider reset");
   div_phase_zero_a: assert property (divider_reset |->
      divider_phase == 4'h0) else $error("divider phase not zero");
   tag_quiet_a: assert property (sample_tag |-> !divider_reset &&
      !link_restart && !monitor_restart) else $error("restart with tag");
   full_band_a: assert property (full_bandwidth |->
      !(downconverter_channel_0 || downconverter_channel_1))
      else $error("channel on in full bandwidth");
   chan_order_a: assert property (downconverter_channel_2 |->
      downconverter_channel_1 && downconverter_channel_0 &&
      downconverter_channel_3) else $error("channel set incomplete");
   bypass_code_a: assert property ($rose(downconverter_bypass) |->
      decimation_code == 4'h0) else $error("bypass with nonzero code");
endmodule // chip_cfg_asserts

bind chip_sync_and_mode_config chip_cfg_asserts chip_cfg_asserts_inst (
   .ref_clk, .srst, .cyc_i, .stb_i, .ack_o, .divider_reset, .link_restart,
   .monitor_restart, .sample_tag, .full_bandwidth, .downconverter_channel_0,
   .downconverter_channel_1, .downconverter_channel_2,
   .downconverter_channel_3, .downconverter_bypass, .decimation_code,
   .divider_phase);

// ### bench/tb.sv
/* table-driven register bench with reference pulse cases
   assumes chip_cfg_consts.vh on the include path */
`timescale 1ns/100ps
`include "chip_cfg_consts.vh"
module tb;
   typedef struct packed {
      logic [11:0] a;
      logic [7:0]  w;
      logic [7:0]  r;
      logic [10:0] o;
   } row_t;
   reg         ref_clk, srst, cyc_i, stb_i, we_i, sysref_pin, sample_valid;
   reg  [13:0] adr_i;
   reg  [3:0]  sel_i;
   reg  [31:0] dat_i, rd, nd, nl, nm, nt;
   wire [31:0] dat_o;
   wire        ack_o, dr, lr, mr, st, qe, fb, c0, c1, c2, c3, by;
   wire [3:0]  ph, dc;
   reg  [3:0]  p0;
   integer     err_total, checks, i;
   row_t       rows [0:8];
   wire [10:0] outs = {qe, fb, c0, c1, c2, c3, by, dc};
   chip_sync_and_mode_config chip_sync_and_mode_config_inst (.ref_clk,
      .srst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .sysref_pin, .sample_valid, .divider_reset(dr), .link_restart(lr),
      .monitor_restart(mr), .sample_tag(st), .divider_phase(ph),
      .q_output_enable(qe), .full_bandwidth(fb),
      .downconverter_channel_0(c0), .downconverter_channel_1(c1),
      .downconverter_channel_2(c2), .downconverter_channel_3(c3),
      .downconverter_bypass(by), .decimation_code(dc));
   initial begin
      ref_clk = 0;
      forever #10 ref_clk = ~ref_clk;
   end
   task chk(input [31:0] s, input [31:0] e);
      checks = checks + 1;
      if (s !== e) begin
         err_total = err_total + 1;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task finish_test;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // single classic cycle; ack sampled at the edge, released after it
   task wb(input w, input [11:0] a, input [7:0] d, input [3:0] s);
      integer n;
      @(posedge ref_clk);
      {cyc_i, stb_i, we_i, sel_i} <= {2'b11, w, s};
      adr_i <= {a, 2'b00};
      dat_i <= {24'h0, d};
      n = 0;
      do begin
         @(posedge ref_clk);
         n = n + 1;
      end while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1) begin
         chk(32'h1, 32'h0);
         finish_test;
      end
      rd = dat_o;
      {cyc_i, stb_i} <= 2'b00;
   endtask
   task sref;
      {nd, nl, nm, nt} = 0;
      @(posedge ref_clk);
      sysref_pin <= 1;
      repeat (12) begin
         @(posedge ref_clk);
         {nd, nl, nm, nt} = {nd + dr, nl + lr, nm + mr, nt + st};
      end
      sysref_pin <= 0;
   endtask
   initial begin
      {srst, cyc_i, stb_i, we_i, sysref_pin, sample_valid} = 6'b100000;
      {adr_i, sel_i, dat_i, err_total, checks} = 0;
      rows = '{{12'h1FF, 8'hFF, 8'h01, 11'h610}, {12'h200, 8'hFF, 8'hEF,
         11'h010}, {12'h200, 8'h01, 8'h01, 11'h510}, {12'h200, 8'h22,
         8'h22, 11'h190}, {12'h200, 8'h03, 8'h03, 11'h5F0}, {12'h200,
         8'h00, 8'h00, 11'h610}, {12'h201, 8'hFF, 8'h0F, 11'h60F},
         {12'h201, 8'h00, 8'h00, 11'h610}, {12'h203, 8'hFF, 8'h00, 11'h610}};
      repeat (12) @(posedge ref_clk);
      srst <= 0;
      for (i = 0; i < 3; i = i + 1) begin
         wb(0, 12'h1FF + i, 8'h00, 4'hF);
         chk(rd, 0);
      end
      chk(outs, 11'h610);
      for (i = 0; i < 9; i = i + 1) begin
         wb(1, rows[i].a, rows[i].w, 4'hF);
         wb(0, rows[i].a, 8'h00, 4'hF);
         chk(rd, rows[i].r);
         chk(outs, rows[i].o);
      end
      sample_valid <= 1;
      p0 = ph;
      sref;
      chk(nt, 1);
      chk(nd + nl + nm, 0);
      p0 = p0 + 4'hD;
      chk(ph, p0);
      wb(0, 12'h202, 8'h00, 4'hF);
      chk(rd, 1);
      wb(1, 12'h200, 8'hFF, 4'hE);
      wb(0, 12'h200, 8'h00, 4'hF);
      chk(rd, 0);
      wb(1, 12'h1FF, 8'h00, 4'hF);
      sref;
      chk(nd, 1);
      chk(nm, 1);
      chk(nt, 0);
      chk(ph, 8);
      sref;
      chk(nd, 1);
      chk(nl, 1);
      chk(ph, 8);
      repeat (4) @(posedge ref_clk);
      sref;
      chk(nl, 0);
      wb(1, 12'h1FF, 8'h01, 4'hF);
      sample_valid <= 0;
      sref;
      chk(nt, 0);
      chk(nd + nl + nm, 0);
      sample_valid <= 1;
      repeat (2) @(posedge ref_clk);
      chk(st, 1);
      wb(1, 12'h200, 8'h03, 4'hF);
      srst <= 1;
      repeat (2) @(posedge ref_clk);
      srst <= 0;
      wb(0, 12'h200, 8'h00, 4'hF);
      chk(rd, 0);
      chk(outs, 11'h610);
      finish_test;
   end
endmodule // tb

// ### hw/cfg_reg8.v
/*
 One 8-bit configuration register with a write mask.
 Assumes writes are single-cycle strobes in the ref_clk domain.
*/
`timescale 1ns/100ps
module cfg_reg8 #(
   parameter [7:0] RESET_VAL = 8'h00,
   parameter [7:0] WR_MASK   = 8'hFF
) (
   input  wire       ref_clk,
   input  wire       srst,
   input  wire       wr_en,
   input  wire [7:0] wr_data,
   output reg  [7:0] value
);

   always @(posedge ref_clk) begin
      if (srst)
         value <= RESET_VAL;
      else if (wr_en)
         value <= wr_data & WR_MASK;
   end

endmodule // cfg_reg8

// ### hw/chip_sync_and_mode_config.v
/*
 Chip-level sync and operating mode configuration bank behind a
 classic Wishbone slave, plus the reference pulse handling it steers.
 Assumes ref_clk is the configuration clock, sysref_pin is asynchronous,
 and sample_valid marks a sample on the same clock.
*/
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "chip_cfg_consts.vh"
module chip_sync_and_mode_config (
   input  wire        ref_clk,
   input  wire        srst,
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [13:0] adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   input  wire        sysref_pin,
   input  wire        sample_valid,
   output reg         divider_reset,
   output reg         link_restart,
   output reg         monitor_restart,
   output reg         sample_tag,
   output reg  [3:0]  divider_phase,
   output reg         q_output_enable,
   output reg         full_bandwidth,
   output reg         downconverter_channel_0,
   output reg         downconverter_channel_1,
   output reg         downconverter_channel_2,
   output reg         downconverter_channel_3,
   output reg         downconverter_bypass,
   output reg  [3:0]  decimation_code
);

   ////////////////////////////////////////////////////////////////////////
   // wishbone slave: one wait state, ack in the cycle after request

   // ack_o blocks a second take of the same held request
   wire        req = cyc_i & stb_i & ~ack_o;
   wire [11:0] idx = adr_i[13:2];
   // write lands on the ack edge, where the master samples ack;
   // only byte lane 0 carries register bits
   wire        wr  = cyc_i & stb_i & ack_o & we_i & sel_i[0];
   wire [7:0]  sync_mode;
   wire [7:0]  chip_mode;
   wire [7:0]  decim;
   reg  [7:0]  next_rd;
   // tag count wraps at 255; software has no clear
   reg  [7:0]  tag_count;

   // bit 0 alone is writable in the sync mode register
   cfg_reg8 #(
      .RESET_VAL (`RST_SYNC_MODE),
      .WR_MASK   (`MASK_SYNC_MODE)
   ) u_sync_mode (
      .ref_clk (ref_clk),
      .srst    (srst),
      .wr_en   (wr && idx == `IDX_SYNC_MODE),
      .wr_data (dat_i[7:0]),
      .value   (sync_mode)
   );

   // reserved bit 4 held at zero by the mask
   cfg_reg8 #(
      .RESET_VAL (`RST_CHIP_MODE),
      .WR_MASK   (`MASK_CHIP_MODE)
   ) u_chip_mode (
      .ref_clk (ref_clk),
      .srst    (srst),
      .wr_en   (wr && idx == `IDX_CHIP_MODE),
      .wr_data (dat_i[7:0]),
      .value   (chip_mode)
   );

   cfg_reg8 #(
      .RESET_VAL (`RST_DECIM),
      .WR_MASK   (`MASK_DECIM)
   ) u_decim (
      .ref_clk (ref_clk),
      .srst    (srst),
      .wr_en   (wr && idx == `IDX_DECIM),
      .wr_data (dat_i[7:0]),
      .value   (decim)
   );

   // unmapped indices read zero and take no write
   always @* begin
      case (idx)
         `IDX_SYNC_MODE:   next_rd = sync_mode;
         `IDX_CHIP_MODE:   next_rd = chip_mode;
         `IDX_DECIM:       next_rd = decim;
         `IDX_SYNC_STATUS: next_rd = tag_count;
         default:          next_rd = 8'h00;
      endcase
   end

   always @(posedge ref_clk) begin
      if (srst) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         ack_o <= req;
         // latched at the take edge, still standing at the ack edge
         if (req && !we_i)
            dat_o <= {24'h000000, next_rd};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reference pulse: synchronise then detect rising edge

   // only sysref_sync reads sysref_meta; sysref_meta may be metastable
   // zero after reset matches the pin's idle level: no false edge
   reg sysref_meta;
   reg sysref_sync;
   reg sysref_last;
   wire sysref_edge = sysref_sync & ~sysref_last;
   wire tstamp_mode = sync_mode[`BIT_SYNC_TSTAMP];

   always @(posedge ref_clk) begin
      if (srst) begin
         sysref_meta <= 1'b0;
         sysref_sync <= 1'b0;
         sysref_last <= 1'b0;
      end else begin
         sysref_meta <= sysref_pin;
         sysref_sync <= sysref_meta;
         sysref_last <= sysref_sync;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // free-running internal divider model; a pulse off phase zero
   // means the reset actually moves the phase, costing the link

   reg pend_tag;

   always @(posedge ref_clk) begin
      if (srst) begin
         divider_phase   <= 4'h0;
         divider_reset   <= 1'b0;
         link_restart    <= 1'b0;
         monitor_restart <= 1'b0;
         sample_tag      <= 1'b0;
         pend_tag        <= 1'b0;
         tag_count       <= 8'h00;
      end else begin
         divider_reset   <= 1'b0;
         link_restart    <= 1'b0;
         monitor_restart <= 1'b0;
         sample_tag      <= 1'b0;
         // mode 1 skips this branch, so the phase keeps counting
         if (sysref_edge && !tstamp_mode) begin
            divider_phase   <= 4'h0;
            divider_reset   <= 1'b1;
            monitor_restart <= 1'b1;
            if (divider_phase != 4'h0) begin
               link_restart <= 1'b1;
            end
         end else begin
            divider_phase <= divider_phase + 4'h1;
         end
         // tag the first sample at or after the pulse
         // a pulse with no sample passing waits in pend_tag
         if (tstamp_mode) begin
            if (sample_valid && (pend_tag || sysref_edge)) begin
               sample_tag <= 1'b1;
               pend_tag   <= 1'b0;
               tag_count  <= tag_count + 8'h01;
            end else if (sysref_edge) begin
               pend_tag <= 1'b1;
            end
         end else begin
            pend_tag <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // operating mode decode; unlisted app codes leave channels off

   wire [3:0] app_mode = chip_mode[`MSB_APP_MODE:0];

   // levels follow a register write by one cycle

   always @(posedge ref_clk) begin
      if (srst) begin
         q_output_enable         <= 1'b1;
         full_bandwidth          <= 1'b1;
         downconverter_channel_0 <= 1'b0;
         downconverter_channel_1 <= 1'b0;
         downconverter_channel_2 <= 1'b0;
         downconverter_channel_3 <= 1'b0;
         downconverter_bypass    <= 1'b1;
         decimation_code         <= `DECIM_BYPASS;
      end else begin
         q_output_enable <= ~chip_mode[`BIT_Q_IGNORE];
         full_bandwidth  <= (app_mode == `APP_FULL_BW);
         downconverter_channel_0 <= (app_mode == `APP_ONE_CHAN) ||
                                    (app_mode == `APP_TWO_CHAN) ||
                                    (app_mode == `APP_FOUR_CHAN);
         downconverter_channel_1 <= (app_mode == `APP_TWO_CHAN) ||
                                    (app_mode == `APP_FOUR_CHAN);
         downconverter_channel_2 <= (app_mode == `APP_FOUR_CHAN);
         downconverter_channel_3 <= (app_mode == `APP_FOUR_CHAN);
         downconverter_bypass <=
            (decim[`MSB_DECIM:0] == `DECIM_BYPASS);
         decimation_code <= decim[`MSB_DECIM:0];
      end
   end

endmodule // chip_sync_and_mode_config

// ### inc/chip_cfg_consts.vh
/*
 Constants for the chip sync and operating mode configuration bank:
 register indices, field positions, reset values and mode encodings.
 Assumes inclusion by bare name from the design files.
*/
`ifndef CHIP_CFG_CONSTS_VH
`define CHIP_CFG_CONSTS_VH

// register indices; byte address is four times the index
`define IDX_SYNC_MODE       12'h1FF
`define IDX_CHIP_MODE       12'h200
`define IDX_DECIM           12'h201
`define IDX_SYNC_STATUS     12'h202

`define RST_SYNC_MODE       8'h00
`define RST_CHIP_MODE       8'h00
`define RST_DECIM           8'h00

`define BIT_SYNC_TSTAMP     0
`define BIT_Q_IGNORE        5
`define MSB_APP_MODE        3
`define MSB_DECIM           3

`define MASK_SYNC_MODE      8'h01
`define MASK_CHIP_MODE      8'hEF
`define MASK_DECIM          8'h0F

`define APP_FULL_BW         4'h0
`define APP_ONE_CHAN        4'h1
`define APP_TWO_CHAN        4'h2
`define APP_FOUR_CHAN       4'h3
`define DECIM_BYPASS        4'h0

`define DIV_WIDTH           4

`endif
